/* clk_sel_pkg.sv */
// Constants, register map and carrier types for the system clock selector
//==============================================================================
// Function
// - Wake timers tick from the low-frequency 32 kHz domain, never the system clock.
// - The system controller sequencer runs from the 1 MHz controller slow oscillator.
// - Low-frequency source is selectable: internal 32.768 kHz oscillator or crystal.
// - Internal high-speed oscillator offers only 48, 32, 24 and 12 MHz settings.
// - With the crystal as source, software picks full or half crystal frequency.
// - Radio clock stays on the crystal whatever the system clock source is.
// - CPU, buses and DMA share one system clock from six source/rate combinations.
// - Asynchronous bridge peripherals get a fixed clock independent of the system clock.
// - Core tick timer runs from the system clock or a divided version of it.
// - Each of twelve SRAM instances has its own clock gate and power switch.
// - Slow oscillator starts first; high-speed oscillator waits for stable regulators.
package clk_sel_pkg;

   //===========================================================================
   // Register map
   localparam logic [3:0] OFS_CTRL     = 4'h0;
   localparam logic [3:0] OFS_SRAM_CLK = 4'h4;
   localparam logic [3:0] OFS_SRAM_PWR = 4'h8;
   localparam logic [3:0] OFS_STATUS   = 4'hC;

   //===========================================================================
   // Sizes
   localparam int SRAM_COUNT   = 12;
   localparam int TICK_DIV_W   = 3;
   localparam int BRIDGE_DIV_W = 1;

   //===========================================================================
   // Control register fields
   localparam int CTRL_HF_XTAL_BIT  = 0;
   localparam int CTRL_XTAL_HALF    = 1;
   localparam int CTRL_OSC_FREQ_LO  = 2;
   localparam int CTRL_LF_XTAL_BIT  = 4;
   localparam int CTRL_TICK_DIV_BIT = 5;
   localparam int CTRL_TICK_RAT_LO  = 6;

   //===========================================================================
   // Oscillator frequency codes
   localparam logic [1:0] OSC_12MHZ = 2'h0;
   localparam logic [1:0] OSC_24MHZ = 2'h1;
   localparam logic [1:0] OSC_32MHZ = 2'h2;
   localparam logic [1:0] OSC_48MHZ = 2'h3;

   //===========================================================================
   // Reset values
   localparam logic [SRAM_COUNT-1:0] SRAM_RST   = 12'hFFF;
   localparam logic [1:0]            OSC_RST    = OSC_48MHZ;
   localparam logic [0:0]            BRIDGE_RAT = 1'h1;

   //===========================================================================
   // Types
   typedef struct packed {
      logic [TICK_DIV_W-1:0] tickRatio;
      logic                  tickDivided;
      logic                  lfXtal;
      logic [1:0]            oscFreq;
      logic                  xtalHalf;
      logic                  hfXtal;
   } ctrl_t;

   typedef struct packed {
      logic [3:0] addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } bus_req_t;

   typedef enum logic [4:0] {
      SEQ_OFF  = 5'h01,
      SEQ_SLOW = 5'h02,
      SEQ_REGS = 5'h04,
      SEQ_HF   = 5'h08,
      SEQ_RUN  = 5'h10
   } seq_t;

endpackage : clk_sel_pkg

/* tick_divider.sv */
// Glitch-free power-of-two divider for clock tick pulses
`timescale 1ns/10ps
module tick_divider #(
   parameter int W = 3
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic         tickIn,
   input  wire logic [W-1:0] ratio,
   output logic              tickOut
);
   localparam int CW = 1 << W;

   logic [CW-1:0] count_reg;
   logic [W-1:0]  ratio_reg;
   logic [CW-1:0] limit;

   assign limit   = CW'((1 << ratio_reg) - 1);
   assign tickOut = tickIn && (count_reg == limit);

   //===========================================================================
   // Ratio only changes at a period boundary
   always_ff @(posedge clk) begin
      if (rst) begin
         count_reg <= '0;
         ratio_reg <= '0;
      end else if (tickIn) begin
         if (count_reg == limit) begin
            count_reg <= '0;
            ratio_reg <= ratio;
         end else begin
            count_reg <= count_reg + 1'b1;
         end
      end
   end
endmodule : tick_divider

/* tick_mux.sv */
// Glitch-free two-input selector for clock tick pulses
`timescale 1ns/10ps
module tick_mux (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic tickA,
   input  wire logic tickB,
   input  wire logic selB,
   output logic      tickOut,
   output logic      activeB
);
   logic enA_reg;
   logic enB_reg;

   assign tickOut = (enA_reg & tickA) | (enB_reg & tickB);
   assign activeB = enB_reg;

   //===========================================================================
   // Old source stops after its own tick, new one starts on its own tick
   always_ff @(posedge clk) begin
      if (rst) begin
         enA_reg <= 1'b1;
         enB_reg <= 1'b0;
      end else if (selB) begin
         if (enA_reg && tickA) enA_reg <= 1'b0;
         if (!enA_reg && !enB_reg && tickB) enB_reg <= 1'b1;
      end else begin
         if (enB_reg && tickB) enB_reg <= 1'b0;
         if (!enA_reg && !enB_reg && tickA) enA_reg <= 1'b1;
      end
   end
endmodule : tick_mux

/* system_clock_select.sv */
// System clock selection, distribution, SRAM gating and start-up sequencing
//
// Chosen here: the plain strobed port and the register offsets.
`timescale 1ns/10ps
module system_clock_select
   import clk_sel_pkg::*;
(
   input  wire logic                  clk,
   input  wire logic                  rst,
   input  wire logic [3:0]            regAddr,
   input  wire logic [31:0]           regWdata,
   input  wire logic                  regWr,
   input  wire logic                  regRd,
   output logic [31:0]                regRdata,
   input  wire logic                  controllerSlowOscTick,
   input  wire logic                  lfOscTick,
   input  wire logic                  lfXtalTick,
   input  wire logic                  freeRunningOscTick,
   input  wire logic                  xtalTick,
   input  wire logic                  regulatorsStable,
   output logic                       controllerSlowOscEnable,
   output logic                       freeRunningOscEnable,
   output logic [1:0]                 freeRunningOscFreq,
   output logic                       controllerTick,
   output logic                       wakeTimerTick,
   output logic                       sysClkTick,
   output logic                       radioClkTick,
   output logic                       bridgeClkTick,
   output logic                       coreTickTimerTick,
   output logic [SRAM_COUNT-1:0]      sramClkEn,
   output logic [SRAM_COUNT-1:0]      sramPwrEn
);
   //===========================================================================
   // Registers
   bus_req_t              req;
   ctrl_t                 ctrl_reg;
   logic [SRAM_COUNT-1:0] sramClk_reg;
   logic [SRAM_COUNT-1:0] sramPwr_reg;
   logic [31:0]           rdata_reg;
   seq_t                  seq_reg;
   logic                  slowEn_reg;
   logic                  oscEn_reg;
   logic [1:0]            oscFreq_reg;
   logic                  oscSeen_reg;

   logic                  xtalPathTick;
   logic                  oscPathTick;
   logic                  hfActiveXtal;
   logic                  lfActiveXtal;
   logic                  tickDivOut;
   logic                  tickActiveDiv;
   logic [31:0]           statusWord;

   assign req = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};

   //===========================================================================
   // Register writes
   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl_reg <= '{tickRatio: '0, tickDivided: 1'b0, lfXtal: 1'b0,
                       oscFreq: OSC_RST, xtalHalf: 1'b0, hfXtal: 1'b0};
      end else if (req.wr && req.addr == OFS_CTRL) begin
         ctrl_reg.hfXtal      <= req.wdata[CTRL_HF_XTAL_BIT];
         ctrl_reg.xtalHalf    <= req.wdata[CTRL_XTAL_HALF];
         ctrl_reg.oscFreq     <= req.wdata[CTRL_OSC_FREQ_LO +: 2];
         ctrl_reg.lfXtal      <= req.wdata[CTRL_LF_XTAL_BIT];
         ctrl_reg.tickDivided <= req.wdata[CTRL_TICK_DIV_BIT];
         ctrl_reg.tickRatio   <= req.wdata[CTRL_TICK_RAT_LO +: TICK_DIV_W];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         sramClk_reg <= SRAM_RST;
      end else if (req.wr && req.addr == OFS_SRAM_CLK) begin
         sramClk_reg <= req.wdata[SRAM_COUNT-1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         sramPwr_reg <= SRAM_RST;
      end else if (req.wr && req.addr == OFS_SRAM_PWR) begin
         sramPwr_reg <= req.wdata[SRAM_COUNT-1:0];
      end
   end

   //===========================================================================
   // Register reads, data one cycle after the strobe
   assign statusWord = {21'h0, seq_reg, oscFreq_reg, tickActiveDiv, lfActiveXtal,
                        hfActiveXtal, regulatorsStable};

   always_ff @(posedge clk) begin
      if (rst) begin
         rdata_reg <= 32'h0;
      end else if (req.rd) begin
         case (req.addr)
            OFS_CTRL:     rdata_reg <= {23'h0, ctrl_reg.tickRatio, ctrl_reg.tickDivided,
                                        ctrl_reg.lfXtal, ctrl_reg.oscFreq,
                                        ctrl_reg.xtalHalf, ctrl_reg.hfXtal};
            OFS_SRAM_CLK: rdata_reg <= {20'h0, sramClk_reg};
            OFS_SRAM_PWR: rdata_reg <= {20'h0, sramPwr_reg};
            OFS_STATUS:   rdata_reg <= statusWord;
            default:      rdata_reg <= 32'h0;
         endcase
      end else begin
         rdata_reg <= 32'h0;
      end
   end

   assign regRdata = rdata_reg;

   //===========================================================================
   // Start-up sequencer, stepped by the controller slow oscillator
   always_ff @(posedge clk) begin
      if (rst) begin
         seq_reg <= SEQ_OFF;
      end else begin
         case (seq_reg)
            SEQ_OFF:  seq_reg <= SEQ_SLOW;
            SEQ_SLOW: if (controllerSlowOscTick) seq_reg <= SEQ_REGS;
            SEQ_REGS: if (controllerSlowOscTick && regulatorsStable) begin
               seq_reg <= SEQ_HF;
            end
            SEQ_HF:   if (controllerSlowOscTick && oscSeen_reg) begin
               seq_reg <= SEQ_RUN;
            end
            SEQ_RUN:  seq_reg <= SEQ_RUN;
            default:  seq_reg <= SEQ_OFF;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         slowEn_reg <= 1'b0;
      end else begin
         slowEn_reg <= (seq_reg != SEQ_OFF);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         oscEn_reg <= 1'b0;
      end else begin
         oscEn_reg <= (seq_reg == SEQ_HF) || (seq_reg == SEQ_RUN);
      end
   end

   // Oscillator seen running; held so start-up cannot stall on tick phase
   always_ff @(posedge clk) begin
      if (rst) begin
         oscSeen_reg <= 1'b0;
      end else if (seq_reg == SEQ_HF && oscPathTick) begin
         oscSeen_reg <= 1'b1;
      end
   end

   //===========================================================================
   // Oscillator frequency setting, taken only while its output is idle
   always_ff @(posedge clk) begin
      if (rst) begin
         oscFreq_reg <= OSC_RST;
      end else if (!oscPathTick) begin
         oscFreq_reg <= ctrl_reg.oscFreq;
      end
   end

   assign controllerSlowOscEnable = slowEn_reg;
   assign freeRunningOscEnable    = oscEn_reg;
   assign freeRunningOscFreq      = oscFreq_reg;
   assign controllerTick          = slowEn_reg & controllerSlowOscTick;

   //===========================================================================
   // Low-frequency domain
   tick_mux u_lfMux (
      .clk     (clk),
      .rst     (rst),
      .tickA   (lfOscTick),
      .tickB   (lfXtalTick),
      .selB    (ctrl_reg.lfXtal),
      .tickOut (wakeTimerTick),
      .activeB (lfActiveXtal)
   );

   //===========================================================================
   // High-frequency system clock
   assign oscPathTick = oscEn_reg & freeRunningOscTick;

   tick_divider #(.W(1)) u_xtalDiv (
      .clk     (clk),
      .rst     (rst),
      .tickIn  (xtalTick),
      .ratio   (ctrl_reg.xtalHalf),
      .tickOut (xtalPathTick)
   );

   tick_mux u_hfMux (
      .clk     (clk),
      .rst     (rst),
      .tickA   (oscPathTick),
      .tickB   (xtalPathTick),
      .selB    (ctrl_reg.hfXtal),
      .tickOut (sysClkTick),
      .activeB (hfActiveXtal)
   );

   assign radioClkTick = xtalTick;

   //===========================================================================
   // Fixed bridge clock, crystal based and independent of selection
   tick_divider #(.W(BRIDGE_DIV_W)) u_bridgeDiv (
      .clk     (clk),
      .rst     (rst),
      .tickIn  (xtalTick),
      .ratio   (BRIDGE_RAT),
      .tickOut (bridgeClkTick)
   );

   //===========================================================================
   // Core tick timer clock
   tick_divider #(.W(TICK_DIV_W)) u_tickDiv (
      .clk     (clk),
      .rst     (rst),
      .tickIn  (sysClkTick),
      .ratio   (ctrl_reg.tickRatio),
      .tickOut (tickDivOut)
   );

   tick_mux u_tickMux (
      .clk     (clk),
      .rst     (rst),
      .tickA   (sysClkTick),
      .tickB   (tickDivOut),
      .selB    (ctrl_reg.tickDivided),
      .tickOut (coreTickTimerTick),
      .activeB (tickActiveDiv)
   );

   //===========================================================================
   // Per-instance SRAM gates
   genvar i;
   generate
      for (i = 0; i < SRAM_COUNT; i++) begin : g_sram
         assign sramPwrEn[i] = sramPwr_reg[i];
         assign sramClkEn[i] = sramClk_reg[i] & sramPwr_reg[i];
      end
   endgenerate

endmodule : system_clock_select

/* clk_sel_monitor.sv */
// Assertion checker for the system clock selector ports
`timescale 1ns/10ps
module clk_sel_monitor
   import clk_sel_pkg::*;
(
   input wire logic                  clk,
   input wire logic                  rst,
   input wire logic                  regRd,
   input wire logic [31:0]           regRdata,
   input wire logic                  controllerSlowOscTick,
   input wire logic                  lfOscTick,
   input wire logic                  lfXtalTick,
   input wire logic                  freeRunningOscTick,
   input wire logic                  xtalTick,
   input wire logic                  regulatorsStable,
   input wire logic                  controllerSlowOscEnable,
   input wire logic                  freeRunningOscEnable,
   input wire logic                  controllerTick,
   input wire logic                  wakeTimerTick,
   input wire logic                  sysClkTick,
   input wire logic                  radioClkTick,
   input wire logic                  bridgeClkTick,
   input wire logic                  coreTickTimerTick,
   input wire logic [SRAM_COUNT-1:0] sramClkEn,
   input wire logic [SRAM_COUNT-1:0] sramPwrEn
);
   //===========================================================================
   // Clock relations
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   radio_follow_a: assert property (radioClkTick == xtalTick)
      else $error("radio clock differs from crystal");
   bridge_fixed_a: assert property (bridgeClkTick |-> xtalTick ##1 !bridgeClkTick[*3] ##1 bridgeClkTick)
      else $error("bridge clock not crystal over two");
   wake_source_a: assert property (wakeTimerTick |-> lfOscTick || lfXtalTick)
      else $error("wake tick without low-frequency tick");
   ctrl_tick_a: assert property (controllerTick == (controllerSlowOscEnable && controllerSlowOscTick))
      else $error("controller tick not from slow oscillator");
   hf_start_a: assert property ($rose(freeRunningOscEnable) |-> regulatorsStable && controllerSlowOscEnable)
      else $error("high-speed oscillator enabled too early");
   sys_source_a: assert property (sysClkTick |-> freeRunningOscTick || xtalTick)
      else $error("system tick without source tick");
   no_runt_a: assert property (sysClkTick |=> !sysClkTick)
      else $error("runt on system clock");
   core_tick_a: assert property (coreTickTimerTick |-> sysClkTick)
      else $error("core tick not on system tick");
   sram_gate_a: assert property ((sramClkEn & ~sramPwrEn) == '0)
      else $error("sram clock on without power");
   rd_idle_a: assert property (!$past(regRd) |-> regRdata == 32'h0)
      else $error("read data outside read slot");
endmodule : clk_sel_monitor

/* osc_model.sv */
// Oscillator and regulator model feeding the clock selector
`timescale 1ns/10ps
module osc_model (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       oscEnable,
   input  wire logic [1:0] oscFreq,
   output logic            slowTick,
   output logic            lfOscTick,
   output logic            lfXtalTick,
   output logic            hsTick,
   output logic            xtalTick,
   output logic            regulatorsStable
);
   logic [31:0] cnt;
   logic [2:0]  oscCnt;
   logic [2:0]  lim;
   //===========================================================================
   // Free-running time base; higher code means shorter period
   assign lim = 3'h4 - {1'b0, oscFreq};
   always_ff @(posedge clk) begin
      if (rst) cnt <= 32'h0;
      else cnt <= cnt + 32'h1;
   end
   always_ff @(posedge clk) begin
      if (rst || !oscEnable || oscCnt >= lim) oscCnt <= 3'h0;
      else oscCnt <= oscCnt + 3'h1;
   end
   assign slowTick         = (cnt % 20) == 0;
   assign lfOscTick        = (cnt % 5) == 0;
   assign lfXtalTick       = (cnt % 6) == 0;
   assign xtalTick         = cnt[0];
   assign hsTick           = oscEnable && oscCnt >= lim;
   assign regulatorsStable = cnt >= 32'h28;
endmodule : osc_model

/* testbench.sv */
// Self-checking testbench for the system clock selector
`timescale 1ns/10ps
module testbench
   import clk_sel_pkg::*;
;
   logic clk = 0, rst = 1, regWr = 0, regRd = 0;
   logic [3:0] regAddr = 4'h0;
   logic [31:0] regWdata = 32'h0, regRdata, d, c, p;
   logic slowT, lfoT, lfxT, hsT, xT, regOk, slowEn, hsEn, ctlT, wakeT, sysT, radT, brgT, coreT;
   logic [1:0] hsFreq;
   logic [SRAM_COUNT-1:0] sramClkEn, sramPwrEn;
   int failCount = 0, nChecks = 0, seed = 32'h1133, i, j, r, lfSel = 0;
   int sysN, coreN, brgN, wakeN, badN, radN, ctlN;
   always #25 clk = ~clk;
   osc_model osc (.clk, .rst, .oscEnable(hsEn), .oscFreq(hsFreq), .slowTick(slowT),
      .lfOscTick(lfoT), .lfXtalTick(lfxT), .hsTick(hsT), .xtalTick(xT), .regulatorsStable(regOk));
   system_clock_select DUT (.clk, .rst, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
      .controllerSlowOscTick(slowT), .lfOscTick(lfoT), .lfXtalTick(lfxT),
      .freeRunningOscTick(hsT), .xtalTick(xT), .regulatorsStable(regOk),
      .controllerSlowOscEnable(slowEn), .freeRunningOscEnable(hsEn),
      .freeRunningOscFreq(hsFreq), .controllerTick(ctlT), .wakeTimerTick(wakeT),
      .sysClkTick(sysT), .radioClkTick(radT), .bridgeClkTick(brgT),
      .coreTickTimerTick(coreT), .sramClkEn, .sramPwrEn);
   //===========================================================================
   // Tasks
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      nChecks++;
      if (seen !== exp) begin
         failCount++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   function automatic int expCount(input int cycles, input int period);
      return cycles / period;
   endfunction : expCount
   task automatic wr(input logic [3:0] a, input logic [31:0] v);
      @(posedge clk);
      regAddr <= a;
      regWdata <= v;
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [31:0] v);
      @(posedge clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      #1 v = regRdata;
   endtask : rd
   task automatic run(input int n);
      sysN = 0;
      coreN = 0;
      brgN = 0;
      wakeN = 0;
      badN = 0;
      radN = 0;
      ctlN = 0;
      repeat (n) begin
         @(posedge clk);
         #1 sysN += sysT;
         coreN += coreT;
         brgN += brgT;
         wakeN += wakeT;
         badN += wakeT && !(lfSel ? lfxT : lfoT);
         radN += radT;
         ctlN += ctlT;
      end
   endtask : run
   task automatic results;
      $display("checks %0d mismatches %0d", nChecks, failCount);
      if (failCount == 0 && nChecks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : results
   //===========================================================================
   // Main sequence
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      #1 check(sramPwrEn, 12'hFFF);
      check(sramClkEn, 12'hFFF);
      check(hsFreq, 2'h3);
      check(hsEn, 1'b0);
      for (i = 0; i < 400 && hsEn !== 1'b1; i++) @(posedge clk);
      if (hsEn !== 1'b1) begin
         failCount++;
         results();
      end
      check(regOk, 1'b1);
      for (i = 0; i < 20 && d[10:6] !== 5'h10; i++) rd(OFS_STATUS, d);
      if (d[10:6] !== 5'h10) begin
         failCount++;
         results();
      end
      check(slowEn, 1'b1);
      wr(OFS_STATUS, 32'h0);
      rd(OFS_STATUS, d);
      check(d[10:6], 5'h10);
      $display("start-up done");
      for (i = 0; i < 4; i++) begin
         wr(OFS_CTRL, 32'(i) << CTRL_OSC_FREQ_LO);
         run(20);
         check(hsFreq, i);
         run(120);
         check(sysN, expCount(120, 5 - i));
         check(brgN, expCount(120, 4));
         check(radN, expCount(120, 2));
         check(ctlN, expCount(120, 20));
      end
      $display("oscillator rates done");
      for (i = 0; i < 2; i++) begin
         wr(OFS_CTRL, 32'h1 | (i << CTRL_XTAL_HALF));
         run(20);
         run(120);
         check(sysN, expCount(120, 2 << i));
         check(coreN, expCount(120, 2 << i));
         check(radN, expCount(120, 2));
         rd(OFS_STATUS, d);
         check(d[1], 1'b1);
      end
      $display("crystal rates done");
      for (j = 0; j < 3; j++) begin
         r = (j == 0) ? 7 : {$random(seed)} % 7;
         wr(OFS_CTRL, 32'h1 | (1 << CTRL_TICK_DIV_BIT) | (r << CTRL_TICK_RAT_LO));
         run(600);
         run(256);
         check(coreN, 128 >> r);
         rd(OFS_STATUS, d);
         check(d[3], 1'b1);
         rd(OFS_CTRL, d);
         check(d, 32'h1 | (1 << CTRL_TICK_DIV_BIT) | (r << CTRL_TICK_RAT_LO));
      end
      $display("tick divider done");
      for (i = 0; i < 2; i++) begin
         lfSel = i;
         wr(OFS_CTRL, i << CTRL_LF_XTAL_BIT);
         run(20);
         run(120);
         check(badN, 0);
         check(wakeN, i ? 20 : 24);
         rd(OFS_STATUS, d);
         check(d[2], i);
      end
      $display("low-frequency select done");
      for (j = 0; j < 4; j++) begin
         c = $random(seed);
         p = (j == 0) ? 32'h0 : $random(seed);
         wr(OFS_SRAM_CLK, c);
         wr(OFS_SRAM_PWR, p);
         @(posedge clk);
         #1 check(sramPwrEn, p[11:0]);
         check(sramClkEn, c[11:0] & p[11:0]);
         rd(OFS_SRAM_PWR, d);
         check(d, p[11:0]);
      end
      rd(4'h2, d);
      check(d, 32'h0);
      $display("sram gating done");
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      #1 check(sramPwrEn, 12'hFFF);
      check(hsEn, 1'b0);
      check(regRdata, 32'h0);
      @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      #1 check(slowEn, 1'b0);
      check(hsFreq, OSC_RST);
      @(posedge clk);
      #1 check(slowEn, 1'b1);
      rd(OFS_CTRL, d);
      check(d, 32'(OSC_RST) << CTRL_OSC_FREQ_LO);
      $display("second reset done");
      results();
   end
endmodule : testbench

bind system_clock_select clk_sel_monitor mon (.clk, .rst, .regRd, .regRdata,
   .controllerSlowOscTick, .lfOscTick, .lfXtalTick, .freeRunningOscTick, .xtalTick,
   .regulatorsStable, .controllerSlowOscEnable, .freeRunningOscEnable, .controllerTick,
   .wakeTimerTick, .sysClkTick, .radioClkTick, .bridgeClkTick, .coreTickTimerTick,
   .sramClkEn, .sramPwrEn);
